// file: design/tiop_top.sv
// Purpose: timed i/o ports, clock blocks and pin sharing
// Assumes: pins and strobes are asynchronous to i_clk
// Notes: reference clock block ticks on every rising i_clk edge
`timescale 1ns/1ps
module tiop_top (
  input wire logic i_clk, // system clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic [31:0] i_pin, // pin levels
  output logic [31:0] o_pin, // pin output levels
  output logic [31:0] o_pin_oe_n, // low while driving
  input wire logic [4:0] i_input_strobe, // per-port input strobe
  output logic [4:0] o_output_strobe, // per-port output strobe
  input wire logic [11:0] i_awaddr, // axi write address
  input wire logic i_awvalid, // axi
  output logic o_awready, // axi
  input wire logic [31:0] i_wdata, // axi write data
  input wire logic [3:0] i_wstrb, // axi byte strobes
  input wire logic i_wvalid, // axi
  output logic o_wready, // axi
  output logic [1:0] o_bresp, // axi
  output logic o_bvalid, // axi
  input wire logic i_bready, // axi
  input wire logic [11:0] i_araddr, // axi read address
  input wire logic i_arvalid, // axi
  output logic o_arready, // axi
  output logic [31:0] o_rdata, // axi read data
  output logic [1:0] o_rresp, // axi
  output logic o_rvalid, // axi
  input wire logic i_rready // axi
);
  localparam int NP = tiop_pkg::NPORT;
  localparam int NB = tiop_pkg::NBLK;
  localparam int CW = tiop_pkg::CW;

  // ==========================================================
  // state
  tiop_pkg::tiop_pctl_type ctl_q [NP];
  tiop_pkg::tiop_pctl_type ctl_d [NP];
  tiop_pkg::tiop_blk_type blk_q [NB];
  tiop_pkg::tiop_blk_type blk_d [NB];
  logic [31:0] shift_q [NP];
  logic [31:0] shift_d [NP];
  logic [31:0] xfer_q [NP];
  logic [31:0] xfer_d [NP];
  logic [31:0] cmp_q [NP];
  logic [31:0] cmp_d [NP];
  logic [CW-1:0] cnt_q [NP];
  logic [CW-1:0] cnt_d [NP];
  logic [CW-1:0] stamp_q [NP];
  logic [CW-1:0] stamp_d [NP];
  logic [CW-1:0] time_q [NP];
  logic [CW-1:0] time_d [NP];
  logic [5:0] sc_q [NP];
  logic [5:0] sc_d [NP];
  logic [7:0] divc_q [NB];
  logic [7:0] divc_d [NB];
  logic [NP-1:0] valid_q, valid_d, timed_q, timed_d, busy_q, busy_d;
  logic [NP-1:0] ostb_q, ostb_d, st_s1_q, st_s2_q;
  logic [NB-1:0] tick_q, tick_d;
  logic [31:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic [31:0] pout_q, pout_d, poe_n_q, poe_n_d;
  logic link_q, link_d;
  logic [11:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d;
  logic [3:0] ws_q, ws_d;
  logic awh_q, awh_d, wh_q, wh_d, bv_q, bv_d, rv_q, rv_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic [31:0] rd_q, rd_d;

  // ==========================================================
  // helpers
  function automatic logic [31:0] wmask(input int w);
    wmask = (w >= 32) ? 32'hffffffff : ((32'h1 << w) - 32'h1);
  endfunction : wmask

  // narrowest enabled port owning the pin, NP when none
  function automatic int pin_owner(input int pin,
                                   input logic [NP-1:0] en,
                                   input logic link);
    pin_owner = NP;
    if (!(link && pin >= tiop_pkg::LINK_PIN_LO)) begin
      for (int p = NP - 1; p >= 0; p--) begin
        if (en[p] && pin < tiop_pkg::port_width(p)) begin
          pin_owner = p;
        end
      end
    end
  endfunction : pin_owner

  // byte-lane merge of a write
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] st);
    for (int b = 0; b < 4; b++) begin
      wmerge[b*8 +: 8] = st[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction : wmerge

  // ==========================================================
  // comb next state
  always_comb begin
    logic [NP-1:0] en;
    logic ext_edge, src, go, in_ok, do_wr, do_rd, hit;
    logic [31:0] pval, nsh;
    logic [5:0] last;
    logic [11:0] a;
    int w, own, pi;
    en = '0;
    ext_edge = 1'b0;
    src = 1'b0;
    go = 1'b0;
    in_ok = 1'b0;
    do_wr = 1'b0;
    do_rd = 1'b0;
    hit = 1'b0;
    pval = '0;
    nsh = '0;
    last = '0;
    a = '0;
    w = 0;
    own = 0;
    pi = 0;
    ctl_d = ctl_q;
    blk_d = blk_q;
    shift_d = shift_q;
    xfer_d = xfer_q;
    cmp_d = cmp_q;
    stamp_d = stamp_q;
    time_d = time_q;
    sc_d = sc_q;
    divc_d = divc_q;
    valid_d = valid_q;
    timed_d = timed_q;
    busy_d = busy_q;
    ostb_d = '0;
    link_d = link_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    awh_d = awh_q;
    wh_d = wh_q;
    bv_d = bv_q;
    br_d = br_q;
    rv_d = rv_q;
    rr_d = rr_q;
    rd_d = rd_q;

    // clock blocks; block 0 is the fixed reference
    ext_edge = pin_s2_q[tiop_pkg::EXT_CLK_PIN] &
               ~pin_s3_q[tiop_pkg::EXT_CLK_PIN];
    for (int k = 0; k < NB; k++) begin
      src = (k != 0 && blk_q[k].ext_src) ? ext_edge : 1'b1;
      tick_d[k] = 1'b0;
      if (src) begin
        if (k == 0 || divc_q[k] == blk_q[k].div) begin
          tick_d[k] = 1'b1;
          divc_d[k] = '0;
        end else begin
          divc_d[k] = divc_q[k] + 8'h01;
        end
      end
    end

    // axi read; access answered next cycle
    do_rd = i_arvalid && !rv_q;
    if (rv_q && i_rready) begin
      rv_d = 1'b0;
    end
    if (do_rd) begin
      a = i_araddr;
      rv_d = 1'b1;
      rd_d = '0;
      rr_d = tiop_pkg::RESP_OKAY;
      pi = int'(a[11:5]);
      if (a < 12'(tiop_pkg::PORT_STRIDE * NP)) begin
        case (a[4:0])
          tiop_pkg::OFF_CTRL: rd_d = 32'(ctl_q[pi]);
          tiop_pkg::OFF_DATA: begin
            rd_d = xfer_q[pi];
            if (!ctl_q[pi].dir_out) begin
              valid_d[pi] = 1'b0; // retrieval frees the register
            end
          end
          tiop_pkg::OFF_COUNT: rd_d = 32'(cnt_q[pi]);
          tiop_pkg::OFF_STAMP: rd_d = 32'(stamp_q[pi]);
          tiop_pkg::OFF_TIME: rd_d = 32'(time_q[pi]);
          tiop_pkg::OFF_COND: rd_d = cmp_q[pi];
          tiop_pkg::OFF_STAT: rd_d = {29'h0, busy_q[pi], timed_q[pi],
                                      valid_q[pi]};
          default: rr_d = tiop_pkg::RESP_SLVERR;
        endcase
      end else if (a >= tiop_pkg::BLK_BASE &&
                   a < tiop_pkg::BLK_BASE + 12'(4 * NB) && a[1:0] == 2'h0) begin
        rd_d = 32'(blk_q[int'(a[4:2])]);
      end else if (a == tiop_pkg::LINK_ADDR) begin
        rd_d = {31'h0, link_q};
      end else begin
        rr_d = tiop_pkg::RESP_SLVERR;
      end
    end

    // port transfers
    for (int p = 0; p < NP; p++) begin
      en[p] = ctl_q[p].en;
    end
    for (int p = 0; p < NP; p++) begin
      w = tiop_pkg::port_width(p);
      last = 6'((32 / w) - 1);
      pval = pin_s2_q & wmask(w);
      go = 1'b0;
      if (ctl_q[p].clk_sel < 3'(NB)) begin
        go = tick_q[ctl_q[p].clk_sel];
      end
      if (go) begin
        cnt_d[p] = cnt_q[p] + 16'h0001;
      end else begin
        cnt_d[p] = cnt_q[p];
      end
      go = go && ctl_q[p].en;
      go = go && (!timed_q[p] || cnt_q[p] == time_q[p]);
      go = go && (!ctl_q[p].strobe_en || st_s2_q[p]);
      case (ctl_q[p].cond)
        tiop_pkg::COND_EQ: in_ok = (pval == (cmp_q[p] & wmask(w)));
        tiop_pkg::COND_NE: in_ok = (pval != (cmp_q[p] & wmask(w)));
        default: in_ok = 1'b1;
      endcase
      if (go && !ctl_q[p].dir_out && in_ok) begin
        nsh = (shift_q[p] >> w) | (pval << (32 - w));
        shift_d[p] = nsh;
        if (sc_q[p] == last) begin
          xfer_d[p] = nsh;
          valid_d[p] = 1'b1;
          stamp_d[p] = cnt_q[p];
          timed_d[p] = 1'b0;
          sc_d[p] = '0;
        end else begin
          sc_d[p] = sc_q[p] + 6'h01;
        end
      end else if (go && ctl_q[p].dir_out) begin
        if (busy_q[p] && sc_q[p] != last) begin
          shift_d[p] = shift_q[p] >> w;
          sc_d[p] = sc_q[p] + 6'h01;
          ostb_d[p] = 1'b1;
        end else if (valid_q[p]) begin
          shift_d[p] = xfer_q[p];
          valid_d[p] = 1'b0;
          busy_d[p] = 1'b1;
          sc_d[p] = '0;
          stamp_d[p] = cnt_q[p];
          timed_d[p] = 1'b0;
          ostb_d[p] = 1'b1;
        end else begin
          busy_d[p] = 1'b0;
        end
      end else if (!ctl_q[p].en) begin
        // disabled port restarts its word; no stale step count
        sc_d[p] = '0;
        busy_d[p] = 1'b0;
      end
    end

    // pin drive; one direction per port
    for (int n = 0; n < tiop_pkg::NPIN; n++) begin
      own = pin_owner(n, en, link_q);
      pout_d[n] = 1'b0;
      poe_n_d[n] = 1'b1;
      for (int p = 0; p < NP; p++) begin
        if (own == p && ctl_q[p].dir_out && busy_q[p]) begin
          pout_d[n] = shift_q[p][n];
          poe_n_d[n] = ctl_q[p].oc && shift_q[p][n];
        end
      end
    end

    // axi write; address and data in either order
    if (i_awvalid && !awh_q) begin
      awa_d = i_awaddr;
      awh_d = 1'b1;
    end
    if (i_wvalid && !wh_q) begin
      wd_d = i_wdata;
      ws_d = i_wstrb;
      wh_d = 1'b1;
    end
    if (bv_q && i_bready) begin
      bv_d = 1'b0;
    end
    do_wr = awh_q && wh_q && !bv_q;
    if (do_wr) begin
      a = awa_q;
      awh_d = 1'b0;
      wh_d = 1'b0;
      bv_d = 1'b1;
      br_d = tiop_pkg::RESP_OKAY;
      pi = int'(a[11:5]);
      hit = 1'b0;
      if (a < 12'(tiop_pkg::PORT_STRIDE * NP)) begin
        hit = 1'b1;
        case (a[4:0])
          tiop_pkg::OFF_CTRL: ctl_d[pi] = tiop_pkg::tiop_pctl_type'(
              wmerge(32'(ctl_q[pi]), wd_q, ws_q) & 32'h1ff);
          tiop_pkg::OFF_DATA: begin
            xfer_d[pi] = wmerge(xfer_q[pi], wd_q, ws_q);
            valid_d[pi] = ctl_q[pi].dir_out;
          end
          tiop_pkg::OFF_TIME: begin
            time_d[pi] = 16'(wmerge(32'(time_q[pi]), wd_q, ws_q));
            timed_d[pi] = 1'b1;
          end
          tiop_pkg::OFF_COND: cmp_d[pi] = wmerge(cmp_q[pi], wd_q, ws_q);
          tiop_pkg::OFF_COUNT, tiop_pkg::OFF_STAMP,
          tiop_pkg::OFF_STAT: hit = 1'b1;
          default: hit = 1'b0;
        endcase
      end else if (a >= tiop_pkg::BLK_BASE &&
                   a < tiop_pkg::BLK_BASE + 12'(4 * NB) && a[1:0] == 2'h0) begin
        hit = 1'b1;
        blk_d[int'(a[4:2])] = tiop_pkg::tiop_blk_type'(
            wmerge(32'(blk_q[int'(a[4:2])]), wd_q, ws_q) & 32'h1ff);
      end else if (a == tiop_pkg::LINK_ADDR) begin
        hit = 1'b1;
        if (ws_q[0]) begin
          link_d = wd_q[0];
        end
      end
      if (!hit) begin
        br_d = tiop_pkg::RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int p = 0; p < NP; p++) begin
        ctl_q[p] <= tiop_pkg::PCTL_RST;
        shift_q[p] <= '0;
        xfer_q[p] <= '0;
        cmp_q[p] <= '0;
        cnt_q[p] <= '0;
        stamp_q[p] <= '0;
        time_q[p] <= '0;
        sc_q[p] <= '0;
      end
      for (int k = 0; k < NB; k++) begin
        blk_q[k] <= tiop_pkg::BLK_RST;
        divc_q[k] <= '0;
      end
      valid_q <= '0;
      timed_q <= '0;
      busy_q <= '0;
      ostb_q <= '0;
      st_s1_q <= '0;
      st_s2_q <= '0;
      tick_q <= '0;
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      pout_q <= '0;
      poe_n_q <= '1;
      link_q <= 1'b0;
      awa_q <= '0;
      wd_q <= '0;
      ws_q <= '0;
      awh_q <= 1'b0;
      wh_q <= 1'b0;
      bv_q <= 1'b0;
      br_q <= '0;
      rv_q <= 1'b0;
      rr_q <= '0;
      rd_q <= '0;
    end else begin
      ctl_q <= ctl_d;
      shift_q <= shift_d;
      xfer_q <= xfer_d;
      cmp_q <= cmp_d;
      cnt_q <= cnt_d;
      stamp_q <= stamp_d;
      time_q <= time_d;
      sc_q <= sc_d;
      blk_q <= blk_d;
      divc_q <= divc_d;
      valid_q <= valid_d;
      timed_q <= timed_d;
      busy_q <= busy_d;
      ostb_q <= ostb_d;
      st_s1_q <= i_input_strobe;
      st_s2_q <= st_s1_q;
      tick_q <= tick_d;
      pin_s1_q <= i_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pout_q <= pout_d;
      poe_n_q <= poe_n_d;
      link_q <= link_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      awh_q <= awh_d;
      wh_q <= wh_d;
      bv_q <= bv_d;
      br_q <= br_d;
      rv_q <= rv_d;
      rr_q <= rr_d;
      rd_q <= rd_d;
    end
  end

  // ==========================================================
  // outputs
  assign o_pin = pout_q;
  assign o_pin_oe_n = poe_n_q;
  assign o_output_strobe = ostb_q;
  assign o_awready = ~awh_q;
  assign o_wready = ~wh_q;
  assign o_bvalid = bv_q;
  assign o_bresp = br_q;
  assign o_arready = ~rv_q;
  assign o_rvalid = rv_q;
  assign o_rdata = rd_q;
  assign o_rresp = rr_q;
endmodule : tiop_top

// file: dv/tb_tiop_top.sv
// Purpose: register-driven tests of the timed i/o ports
// Assumes: ports from pin 0 upward, 0x20 per port
// Notes: reference block ticks each cycle, so one step per cycle
`timescale 1ns/1ps
module tb_tiop_top;
  logic i_clk = 1'h0;
  logic i_rst_n = 1'h0;
  logic [31:0] pin_w, o_pin, oe_n, rdata;
  logic [31:0] drv = 32'h0, val = 32'h0, wdata = 32'h0;
  logic [4:0] o_output_strobe;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, stb = 1'h0;
  logic [4:0] istb = 5'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int n_errors = 0, checks = 0, cyc = 0, t_rd = 0;

  always #12.5 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (o_output_strobe[0] === 1'h1) stb <= 1'h1;
  end

  tiop_top i_tiop_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pin(pin_w),
    .o_pin(o_pin), .o_pin_oe_n(oe_n), .i_input_strobe(istb),
    .o_output_strobe(o_output_strobe), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));

  tiop_ext_hw i_tiop_ext_hw (.i_pin(o_pin), .i_oe_n(oe_n), .i_drv(drv),
    .i_val(val), .o_pin(pin_w));

  // ==========================================================
  // helpers
  task automatic conclude;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic tmo(input int n);
    if (n >= 200) begin
      n_errors++;
      $display("MISMATCH timeout exp 0 got 1");
      conclude();
    end
  endtask : tmo

  // entered just after a rising edge; master holds until taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 200; n++) begin
      @(posedge i_clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    tmo(n);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 200; n++) begin
      @(posedge i_clk);
      if (arvalid && arready) begin
        arvalid <= 1'h0;
        t_rd = cyc;
      end
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    tmo(n);
  endtask : rd

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk($sformatf("reg %h", a), e, d);
  endtask : rc

  // waits for the enable of pin b to reach level v
  task automatic wpin(input int b, input logic v);
    int n;
    for (n = 0; n < 200; n++) begin
      @(posedge i_clk);
      if (oe_n[b] === v) break;
    end
    tmo(n);
  endtask : wpin

  // ==========================================================
  // sequence
  initial begin
    logic [31:0] d, c1;
    logic [1:0] r;
    int t1;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'h1;
    @(posedge i_clk);
    chk("oe_n", 32'hffffffff, oe_n);
    for (int p = 0; p < 5; p++) rc(12'(32 * p), 32'h0);
    for (int k = 0; k < 6; k++) rc(12'(512 + 4 * k), 32'h0);
    rd(12'h400, d, r);
    chk("rresp", 32'h2, {30'h0, r});
    wr(12'h400, 32'h1, 2'h2);
    rd(12'h008, c1, r);
    t1 = t_rd;
    rd(12'h008, d, r);
    chk("count", (c1 + 32'(t_rd - t1)) & 32'hffff, d);
    wr(12'h204, 32'h3, 2'h0);
    wr(12'h040, 32'h40, 2'h0);
    rd(12'h048, c1, r);
    drv <= 32'h1;
    for (int n = 0; n < 6; n++) begin
      val <= 32'h1;
      repeat (3) @(posedge i_clk);
      val <= 32'h0;
      repeat (3) @(posedge i_clk);
    end
    drv <= 32'h0;
    repeat (4) @(posedge i_clk);
    rc(12'h048, (c1 + 32'h3) & 32'hffff);
    wr(12'h000, 32'h3, 2'h0);
    wr(12'h004, 32'h1, 2'h0);
    wpin(0, 1'h0);
    chk("pin0", 32'h1, {31'h0, o_pin[0]});
    wpin(0, 1'h1);
    rd(12'h008, c1, r);
    wr(12'h010, (c1 + 32'h3c) & 32'hffff, 2'h0);
    wr(12'h004, 32'h1, 2'h0);
    wpin(0, 1'h0);
    rc(12'h00c, (c1 + 32'h3c) & 32'hffff);
    wpin(0, 1'h1);
    wr(12'h000, 32'h7, 2'h0);
    wr(12'h004, 32'h2, 2'h0);
    wpin(0, 1'h0);
    chk("oc low", 32'h0, {31'h0, o_pin[0]});
    @(posedge i_clk);
    chk("oc float", 32'h1, {31'h0, oe_n[0]});
    wpin(0, 1'h1);
    wr(12'h000, 32'h0, 2'h0);
    val <= 32'ha;
    drv <= 32'hf;
    repeat (4) @(posedge i_clk);
    wr(12'h020, 32'h1, 2'h0);
    chk("oe in", 32'hf, {28'h0, oe_n[3:0]});
    for (int n = 0; n < 20; n++) begin
      rd(12'h038, d, r);
      if (d[0]) break;
    end
    chk("valid", 32'h1, {31'h0, d[0]});
    wr(12'h020, 32'h0, 2'h0);
    rc(12'h024, 32'haaaaaaaa);
    drv <= 32'h0;
    wr(12'h020, 32'h3, 2'h0);
    wr(12'h000, 32'h3, 2'h0);
    wr(12'h004, 32'h0, 2'h0);
    wr(12'h024, 32'hffffffff, 2'h0);
    wpin(1, 1'h0);
    chk("shared", 32'he, {28'h0, o_pin[3:0]});
    wpin(0, 1'h1);
    wr(12'h000, 32'h0, 2'h0);
    wr(12'h020, 32'h0, 2'h0);
    wr(12'h300, 32'h1, 2'h0);
    wr(12'h080, 32'h3, 2'h0);
    wr(12'h084, 32'hffffffff, 2'h0);
    wpin(0, 1'h0);
    chk("link oe", 32'hffff0000, oe_n);
    chk("strobe", 32'h1, {31'h0, stb});
    wr(12'h000, 32'h19, 2'h0);
    drv <= 32'h1;
    val <= 32'h1;
    istb <= 5'h1;
    repeat (40) @(posedge i_clk);
    rc(12'h018, 32'h0);
    istb <= 5'h0;
    wr(12'h014, 32'h1, 2'h0);
    repeat (40) @(posedge i_clk);
    rc(12'h018, 32'h0);
    istb <= 5'h1;
    repeat (40) @(posedge i_clk);
    istb <= 5'h0;
    repeat (4) @(posedge i_clk);
    rc(12'h018, 32'h1);
    rc(12'h004, 32'hffffffff);
    conclude();
  end
endmodule : tb_tiop_top

// file: dv/tiop_ext_hw.sv
// Purpose: hardware attached to the pins, as seen by the port block
// Assumes: every pin has a pull-down, as on the device
// Notes: device drive wins; the bench picks which pins we drive
`timescale 1ns/1ps
module tiop_ext_hw (
  input wire logic [31:0] i_pin, // device pin levels
  input wire logic [31:0] i_oe_n, // device enables, low drives
  input wire logic [31:0] i_drv, // pins driven from outside
  input wire logic [31:0] i_val, // levels driven from outside
  output logic [31:0] o_pin // resolved wire levels
);
  // ==========================================================
  // wire resolution
  // undriven pins fall to the pull-down, never keep old value
  always_comb begin
    for (int b = 0; b < 32; b++) begin
      o_pin[b] = !i_oe_n[b] ? i_pin[b] : (i_drv[b] & i_val[b]);
    end
  end
endmodule : tiop_ext_hw

// file: dv/tiop_top_assertions.sv
// Purpose: port-level protocol checks on the timed i/o block
// Assumes: one clock, async active-low reset
// Notes: pin timing is judged by the bench
`timescale 1ns/1ps
module tiop_top_chk (
  input wire logic i_clk, // clock
  input wire logic i_rst_n, // reset
  input wire logic [31:0] o_pin_oe_n, // enables
  input wire logic [4:0] o_output_strobe, // strobes
  input wire logic i_awvalid, // axi
  input wire logic o_awready, // axi
  input wire logic i_wvalid, // axi
  input wire logic o_wready, // axi
  input wire logic [1:0] o_bresp, // axi
  input wire logic o_bvalid, // axi
  input wire logic i_bready, // axi
  input wire logic i_arvalid, // axi
  input wire logic o_arready, // axi
  input wire logic [31:0] o_rdata, // axi
  input wire logic o_rvalid, // axi
  input wire logic i_rready // axi
);
  // ==========================================================
  // checks
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  AST_RESET_IDLE: assert property ($rose(i_rst_n) |->
    &o_pin_oe_n && !o_bvalid && !o_rvalid) else $error("reset state");
  AST_B_HOLD: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp)) else $error("bvalid dropped");
  AST_R_HOLD: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata)) else $error("rvalid dropped");
  AST_AR_BLOCK: assert property (o_rvalid |-> !o_arready)
    else $error("arready with rvalid");
  AST_W_ANSWER: assert property (i_awvalid && o_awready && i_wvalid &&
    o_wready |-> ##[1:3] o_bvalid) else $error("no write answer");
  AST_R_ANSWER: assert property (i_arvalid && o_arready |->
    ##[1:2] o_rvalid) else $error("no read answer");
  AST_B_DROP: assert property (o_bvalid && i_bready |=> !o_bvalid)
    else $error("bvalid stuck");
  AST_R_DROP: assert property (o_rvalid && i_rready |=> !o_rvalid)
    else $error("rvalid stuck");
  AST_BRESP_CODE: assert property (o_bvalid |->
    o_bresp == 2'h0 || o_bresp == 2'h2) else $error("bad bresp");
  COV_WR: cover property (o_bvalid && o_bresp == 2'h2);
  COV_RD: cover property (i_arvalid && o_arready);
  COV_STB: cover property (o_output_strobe[0]);
endmodule : tiop_top_chk

bind tiop_top tiop_top_chk i_tiop_top_chk (.i_clk, .i_rst_n, .o_pin_oe_n,
  .o_output_strobe, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bresp,
  .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rdata, .o_rvalid,
  .i_rready);

// file: pkg/tiop_pkg.sv
// Purpose: constants and types for the timed i/o port block
// Assumes: one 40 MHz clock, AXI4-Lite register access
// Notes: ports are ordered narrowest first; pin sharing relies on it
package tiop_pkg;
  // ==========================================================
  // sizes
  localparam int NPORT = 5;
  localparam int NBLK = 6;
  localparam int NPIN = 32;
  localparam int DW = 32;
  localparam int AW = 12;
  localparam int CW = 16;
  localparam int LINK_PIN_LO = 16;
  localparam int EXT_CLK_PIN = 0;

  // ==========================================================
  // register map
  localparam logic [AW-1:0] PORT_STRIDE = 12'h020;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_DATA = 5'h04;
  localparam logic [4:0] OFF_COUNT = 5'h08;
  localparam logic [4:0] OFF_STAMP = 5'h0c;
  localparam logic [4:0] OFF_TIME = 5'h10;
  localparam logic [4:0] OFF_COND = 5'h14;
  localparam logic [4:0] OFF_STAT = 5'h18;
  localparam logic [AW-1:0] BLK_BASE = 12'h200;
  localparam logic [AW-1:0] LINK_ADDR = 12'h300;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // types
  typedef enum logic [1:0] {COND_NONE, COND_EQ, COND_NE} tiop_cond_type;

  typedef struct packed {
    logic [2:0] clk_sel;
    tiop_cond_type cond;
    logic strobe_en;
    logic oc;
    logic dir_out;
    logic en;
  } tiop_pctl_type;

  typedef struct packed {
    logic [7:0] div;
    logic ext_src;
  } tiop_blk_type;

  localparam tiop_pctl_type PCTL_RST = '0;
  localparam tiop_blk_type BLK_RST = '0;

  function automatic int port_width(input int p);
    case (p)
      0: return 1;
      1: return 4;
      2: return 8;
      3: return 16;
      default: return 32;
    endcase
  endfunction : port_width
endpackage : tiop_pkg
